// ===== hdl/bkrc_pkg.sv
// Shared constants for the four-converter step-down regulator control block.
package bkrc_pkg;

  // ---------------------------------------------------------------------------
  // Structure
  // ---------------------------------------------------------------------------
  localparam int NUM_CONV = 4;
  localparam int CODE_W = 8;
  localparam int NUM_PINS = 5;
  localparam int PIN_SEL_W = 3;
  localparam logic [2:0] PIN_NONE = 3'h7;

  // ---------------------------------------------------------------------------
  // Voltage step sizes
  // ---------------------------------------------------------------------------
  localparam int STEP_MV_STD = 10;
  localparam int STEP_MV_CONV3 = 20;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_KHZ = 25000;
  localparam int STEP_TIME_NS_0 = 1000;
  localparam int STEP_TIME_NS_1 = 2000;
  localparam int STEP_TIME_NS_2 = 4000;
  localparam int STEP_TIME_NS_3 = 8000;
  localparam int STEP_CYC_0 = (STEP_TIME_NS_0 * CLK_KHZ + 999_999) / 1_000_000;
  localparam int STEP_CYC_1 = (STEP_TIME_NS_1 * CLK_KHZ + 999_999) / 1_000_000;
  localparam int STEP_CYC_2 = (STEP_TIME_NS_2 * CLK_KHZ + 999_999) / 1_000_000;
  localparam int STEP_CYC_3 = (STEP_TIME_NS_3 * CLK_KHZ + 999_999) / 1_000_000;
  localparam int START_TIME_US = 1000;
  localparam int START_CODES = 255;
  localparam int START_STEP_CYC = (START_TIME_US * (CLK_KHZ / 1000)) / START_CODES;
  localparam int SLOW_START_FACTOR = 4;
  localparam int SLOW_START_STEP_CYC = START_STEP_CYC * SLOW_START_FACTOR;
  localparam int TICK_W = 16;

  // ---------------------------------------------------------------------------
  // Operating mode field encodings
  // ---------------------------------------------------------------------------
  localparam logic [1:0] MODE_BY_PRESET = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_SYNC = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;

  typedef enum logic [1:0] {
    BKRC_OFF = 2'b00,
    BKRC_START = 2'b01,
    BKRC_RUN = 2'b11,
    BKRC_DISCH = 2'b10
  } bkrc_ramp_t;

endpackage

// ===== hdl/bkrc_sync.sv
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/100ps
`default_nettype none
module bkrc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= '0;
      syncOut <= '0;
    end else if (clkEn) begin
      stage1_r <= asyncIn;
      syncOut <= stage1_r;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/bkrc_ramp.sv
// Per-converter voltage code ramp with start-up and discharge sequencing.
`timescale 1ns/100ps
`default_nettype none
module bkrc_ramp
  import bkrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic enable,
  input wire logic [CODE_W-1:0] target,
  input wire logic slewTick,
  input wire logic startTick,
  input wire logic dischargeEn,
  output logic [CODE_W-1:0] applied,
  output logic powerOn,
  output logic atTarget
);

  bkrc_ramp_t state_r;
  logic stepNow;

  // Start-up paces on its own tick; every other move uses the common step time.
  always_comb begin
    stepNow = (state_r == BKRC_START) ? startTick : slewTick;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= BKRC_OFF;
    end else if (clkEn) begin
      case (state_r)
        BKRC_OFF: begin
          if (enable) begin
            state_r <= BKRC_START;
          end
        end
        BKRC_START: begin
          if (!enable) begin
            state_r <= dischargeEn ? BKRC_DISCH : BKRC_OFF;
          end else if (applied == target) begin
            state_r <= BKRC_RUN;
          end
        end
        BKRC_RUN: begin
          if (!enable) begin
            state_r <= dischargeEn ? BKRC_DISCH : BKRC_OFF;
          end
        end
        BKRC_DISCH: begin
          if (enable) begin
            state_r <= BKRC_RUN;
          end else if (applied == CODE_RESET) begin
            state_r <= BKRC_OFF;
          end
        end
        default: state_r <= BKRC_OFF;
      endcase
    end
  end

  // One code per tick in either direction, so every intermediate code is visited while powered.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      applied <= CODE_RESET;
    end else if (clkEn) begin
      if (state_r == BKRC_OFF && !enable) begin
        applied <= CODE_RESET;
      end else if (state_r == BKRC_DISCH) begin
        if (stepNow && applied != CODE_RESET) begin
          applied <= applied - 8'h01;
        end
      end else if (state_r != BKRC_OFF && stepNow) begin
        if (applied < target) begin
          applied <= applied + 8'h01;
        end else if (applied > target) begin
          applied <= applied - 8'h01;
        end
      end
    end
  end

  always_comb begin
    powerOn = (state_r != BKRC_OFF);
    // A discharging converter is done only at code zero, whatever its preset says.
    atTarget = (state_r == BKRC_OFF || state_r == BKRC_DISCH) ? (applied == CODE_RESET)
                                                              : (applied == target);
  end

endmodule
`default_nettype wire

// ===== hdl/bkrc_top.sv
// Control logic for four step-down converters: enables, presets, ramping and pins.
`timescale 1ns/100ps
`default_nettype none
module bkrc_top
  import bkrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [NUM_CONV-1:0] convRegEnable,
  input wire logic [NUM_CONV*PIN_SEL_W-1:0] convEnablePinSel,
  input wire logic [NUM_CONV-1:0] convSeqEnable,
  input wire logic [NUM_PINS-1:0] generalInputPin,
  input wire logic [NUM_CONV*CODE_W-1:0] convVoltagePresetA,
  input wire logic [NUM_CONV*CODE_W-1:0] convVoltagePresetB,
  input wire logic [NUM_CONV-1:0] convPresetSelect,
  input wire logic [NUM_CONV*PIN_SEL_W-1:0] convPresetPinSel,
  input wire logic [NUM_CONV-1:0] convPresetAuto,
  input wire logic powerModeSelectB,
  input wire logic [1:0] slewStepSel,
  input wire logic slowStartupEnable,
  input wire logic activeDischargeEnable,
  input wire logic [NUM_CONV*2-1:0] convCurrentLimitSel,
  input wire logic [NUM_CONV-1:0] convCurrentLimitHit,
  input wire logic [NUM_CONV*2-1:0] convOperatingMode,
  input wire logic [NUM_CONV-1:0] convSleepOnPresetA,
  input wire logic [NUM_CONV-1:0] convSleepOnPresetB,
  input wire logic conv1FullCurrent,
  input wire logic conv2FullCurrent,
  input wire logic dualPhaseMerge,
  input wire logic conv2PulldownDisable,
  input wire logic terminationEnable,
  input wire logic terminationRefOutEnable,
  input wire logic voltageReadyClear,
  output logic [NUM_CONV*CODE_W-1:0] convAppliedCode,
  output logic [NUM_CONV-1:0] convPowerOn,
  output logic [NUM_CONV-1:0] convPresetBActive,
  output logic [NUM_CONV*2-1:0] convCurrentLimitOut,
  output logic [NUM_CONV-1:0] convDutyLimit,
  output logic [NUM_CONV-1:0] convForcePwm,
  output logic [NUM_CONV-1:0] convForcePfm,
  output logic [NUM_CONV-1:0] convAutoMode,
  output logic [1:0] halfPassDisable,
  output logic conv2PulldownOff,
  output logic conv4RefFromSupplyHalf,
  output logic conv4RefFromDac,
  output logic refBufferEnable,
  output logic pin0MemorySupplyInput,
  output logic pin1TerminationRefOutput,
  output logic [NUM_PINS-1:0] pinDigitalEnable,
  output logic [NUM_PINS-1:0] generalInputValid,
  output logic voltageReadyEvent
);

  // ---------------------------------------------------------------------------
  // Pin synchronisation and analog muxing
  // ---------------------------------------------------------------------------
  logic [NUM_PINS-1:0] pinSync;
  logic [NUM_PINS-1:0] pinAnalog;
  logic [NUM_PINS-1:0] pinUsable;

  bkrc_sync #(
    .WIDTH(NUM_PINS)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .asyncIn(generalInputPin),
    .syncOut(pinSync)
  );

  always_comb begin
    pinAnalog = '0;
    pinAnalog[0] = terminationEnable | terminationRefOutEnable;
    pinAnalog[1] = terminationRefOutEnable;
    pinUsable = pinSync & ~pinAnalog;
  end

  // Overcurrent comes from an analog comparator, so it crosses like a pin.
  logic [NUM_CONV-1:0] limitSync;

  bkrc_sync #(
    .WIDTH(NUM_CONV)
  ) u_lim_sync (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .asyncIn(convCurrentLimitHit),
    .syncOut(limitSync)
  );

  // ---------------------------------------------------------------------------
  // Effective controls with dual-phase merge
  // ---------------------------------------------------------------------------
  // When merged the second phase simply mirrors the first, which keeps both
  // inductors driven in step instead of leaving the second one free running.
  logic [NUM_CONV-1:0] effRegEn;
  logic [NUM_CONV-1:0] effSeqEn;
  logic [NUM_CONV*PIN_SEL_W-1:0] effEnPin;
  logic [NUM_CONV*CODE_W-1:0] effPresetA;
  logic [NUM_CONV*CODE_W-1:0] effPresetB;
  logic [NUM_CONV-1:0] effSel;
  logic [NUM_CONV*PIN_SEL_W-1:0] effSelPin;
  logic [NUM_CONV-1:0] effAuto;
  logic [NUM_CONV*2-1:0] effIlim;
  logic [NUM_CONV*2-1:0] effMode;
  logic [NUM_CONV-1:0] effSlA;
  logic [NUM_CONV-1:0] effSlB;
  logic effFull2;

  always_comb begin
    effRegEn = convRegEnable;
    effSeqEn = convSeqEnable;
    effEnPin = convEnablePinSel;
    effPresetA = convVoltagePresetA;
    effPresetB = convVoltagePresetB;
    effSel = convPresetSelect;
    effSelPin = convPresetPinSel;
    effAuto = convPresetAuto;
    effIlim = convCurrentLimitSel;
    effMode = convOperatingMode;
    effSlA = convSleepOnPresetA;
    effSlB = convSleepOnPresetB;
    effFull2 = conv2FullCurrent;
    if (dualPhaseMerge) begin
      effRegEn[1] = convRegEnable[0];
      effSeqEn[1] = convSeqEnable[0];
      effEnPin[PIN_SEL_W +: PIN_SEL_W] = convEnablePinSel[0 +: PIN_SEL_W];
      effPresetA[CODE_W +: CODE_W] = convVoltagePresetA[0 +: CODE_W];
      effPresetB[CODE_W +: CODE_W] = convVoltagePresetB[0 +: CODE_W];
      effSel[1] = convPresetSelect[0];
      effSelPin[PIN_SEL_W +: PIN_SEL_W] = convPresetPinSel[0 +: PIN_SEL_W];
      effAuto[1] = convPresetAuto[0];
      effIlim[3:2] = convCurrentLimitSel[1:0];
      effMode[3:2] = convOperatingMode[1:0];
      effSlA[1] = convSleepOnPresetA[0];
      effSlB[1] = convSleepOnPresetB[0];
      effFull2 = conv1FullCurrent;
    end
  end

  // ---------------------------------------------------------------------------
  // Enable sources and preset selection
  // ---------------------------------------------------------------------------
  logic [NUM_CONV-1:0] convEnable;
  logic [NUM_CONV-1:0] selB;
  logic [NUM_CONV*CODE_W-1:0] target;

  function automatic logic pinLevel(input logic [PIN_SEL_W-1:0] sel,
                                    input logic [NUM_PINS-1:0] pins);
    logic lvl;
    lvl = 1'b0;
    if (sel < PIN_SEL_W'(NUM_PINS)) begin
      lvl = pins[sel];
    end
    return lvl;
  endfunction

  always_comb begin
    for (int i = 0; i < NUM_CONV; i++) begin
      convEnable[i] = effRegEn[i] | effSeqEn[i]
                      | pinLevel(effEnPin[i*PIN_SEL_W +: PIN_SEL_W], pinUsable);
      if (effAuto[i]) begin
        selB[i] = powerModeSelectB;
      end else if (effSelPin[i*PIN_SEL_W +: PIN_SEL_W] != PIN_NONE) begin
        selB[i] = pinLevel(effSelPin[i*PIN_SEL_W +: PIN_SEL_W], pinUsable);
      end else begin
        selB[i] = effSel[i];
      end
      target[i*CODE_W +: CODE_W] = selB[i] ? effPresetB[i*CODE_W +: CODE_W]
                                           : effPresetA[i*CODE_W +: CODE_W];
    end
  end

  // ---------------------------------------------------------------------------
  // Common step timing
  // ---------------------------------------------------------------------------
  // A single tick is shared so every converter outside start-up steps in lockstep; its slope
  // then differs only by its own code step size.
  logic [TICK_W-1:0] slewCnt_r;
  logic [TICK_W-1:0] slewLimit;
  logic slewTick;
  logic [TICK_W-1:0] startCnt_r;
  logic [TICK_W-1:0] startLimit;
  logic startTick;

  always_comb begin
    case (slewStepSel)
      2'h0: slewLimit = TICK_W'(STEP_CYC_0 - 1);
      2'h1: slewLimit = TICK_W'(STEP_CYC_1 - 1);
      2'h2: slewLimit = TICK_W'(STEP_CYC_2 - 1);
      default: slewLimit = TICK_W'(STEP_CYC_3 - 1);
    endcase
    startLimit = slowStartupEnable ? TICK_W'(SLOW_START_STEP_CYC - 1)
                                   : TICK_W'(START_STEP_CYC - 1);
    slewTick = (slewCnt_r >= slewLimit);
    startTick = (startCnt_r >= startLimit);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slewCnt_r <= '0;
    end else if (clkEn) begin
      slewCnt_r <= slewTick ? '0 : slewCnt_r + TICK_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startCnt_r <= '0;
    end else if (clkEn) begin
      startCnt_r <= startTick ? '0 : startCnt_r + TICK_W'(1);
    end
  end

  // ---------------------------------------------------------------------------
  // Ramp engines
  // ---------------------------------------------------------------------------
  logic [NUM_CONV-1:0] atTarget;

  // Codes are in units of each converter's own step: the third converter's
  // code counts 20 mV, the others 10 mV, so the same tick gives twice the slope.
  for (genvar g = 0; g < NUM_CONV; g++) begin : g_conv
    bkrc_ramp u_ramp (
      .clk(clk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .enable(convEnable[g]),
      .target(target[g*CODE_W +: CODE_W]),
      .slewTick(slewTick),
      .startTick(startTick),
      .dischargeEn(activeDischargeEnable),
      .applied(convAppliedCode[g*CODE_W +: CODE_W]),
      .powerOn(convPowerOn[g]),
      .atTarget(atTarget[g])
    );
  end

  // ---------------------------------------------------------------------------
  // Ready event
  // ---------------------------------------------------------------------------
  logic rampPending_r;
  logic allDone;

  always_comb begin
    allDone = &atTarget;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rampPending_r <= 1'b0;
    end else if (clkEn) begin
      rampPending_r <= !allDone;
    end
  end

  // A completion in the same cycle as a clear keeps the flag set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      voltageReadyEvent <= 1'b0;
    end else if (clkEn) begin
      if (rampPending_r && allDone) begin
        voltageReadyEvent <= 1'b1;
      end else if (voltageReadyClear) begin
        voltageReadyEvent <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Mode, current limit and pass devices
  // ---------------------------------------------------------------------------
  // Automatic mode is passed through but not recommended for software to use.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      convForcePwm <= '0;
      convForcePfm <= '0;
      convAutoMode <= '0;
      convPresetBActive <= '0;
    end else if (clkEn) begin
      convPresetBActive <= selB;
      for (int i = 0; i < NUM_CONV; i++) begin
        if ((selB[i] && effSlB[i]) || (!selB[i] && effSlA[i])) begin
          convForcePwm[i] <= 1'b0;
          convForcePfm[i] <= 1'b1;
          convAutoMode[i] <= 1'b0;
        end else begin
          case (effMode[i*2 +: 2])
            MODE_SLEEP: begin
              convForcePwm[i] <= 1'b0;
              convForcePfm[i] <= 1'b1;
              convAutoMode[i] <= 1'b0;
            end
            MODE_AUTO: begin
              convForcePwm[i] <= 1'b0;
              convForcePfm[i] <= 1'b0;
              convAutoMode[i] <= 1'b1;
            end
            default: begin
              convForcePwm[i] <= 1'b1;
              convForcePfm[i] <= 1'b0;
              convAutoMode[i] <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Overcurrent only limits duty cycle; the enable path never sees it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      convCurrentLimitOut <= '0;
      convDutyLimit <= '0;
    end else if (clkEn) begin
      convCurrentLimitOut <= effIlim;
      convDutyLimit <= limitSync & convPowerOn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halfPassDisable <= '0;
      conv2PulldownOff <= 1'b0;
    end else if (clkEn) begin
      halfPassDisable <= {!effFull2, !conv1FullCurrent};
      conv2PulldownOff <= conv2PulldownDisable;
    end
  end

  // ---------------------------------------------------------------------------
  // Termination reference and pin functions
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv4RefFromSupplyHalf <= 1'b0;
      conv4RefFromDac <= 1'b1;
      refBufferEnable <= 1'b0;
      pin0MemorySupplyInput <= 1'b0;
      pin1TerminationRefOutput <= 1'b0;
      pinDigitalEnable <= '1;
      generalInputValid <= '0;
    end else if (clkEn) begin
      conv4RefFromSupplyHalf <= terminationEnable;
      conv4RefFromDac <= !terminationEnable;
      refBufferEnable <= terminationEnable & terminationRefOutEnable;
      pin0MemorySupplyInput <= pinAnalog[0];
      pin1TerminationRefOutput <= pinAnalog[1];
      pinDigitalEnable <= ~pinAnalog;
      generalInputValid <= pinUsable;
    end
  end

endmodule
`default_nettype wire

// ===== tb/bkrc_host_model.sv
// Far-side model: sequencer steps, input pins and converter mode settings.
`timescale 1ns/100ps
`default_nettype none
module bkrc_host_model
  import bkrc_pkg::*;
(
  input wire logic [NUM_CONV-1:0] seqStep,
  input wire logic [NUM_PINS-1:0] pinLevel,
  input wire logic [NUM_CONV*2-1:0] modeReq,
  input wire logic [NUM_CONV-1:0] sleepReqA,
  input wire logic memTerm,
  output logic [NUM_CONV-1:0] convSeqEnable,
  output logic [NUM_PINS-1:0] generalInputPin,
  output logic [NUM_CONV*2-1:0] convOperatingMode,
  output logic [NUM_CONV-1:0] convSleepOnPresetA
);
  // ---------------------------------------------------------------------------
  // Settings
  // ---------------------------------------------------------------------------
  assign convSeqEnable = seqStep;
  assign generalInputPin = pinLevel;
  // Termination use needs the fourth converter left in mode 0 with no sleep link.
  assign convOperatingMode = memTerm ? {2'h0, modeReq[5:0]} : modeReq;
  assign convSleepOnPresetA = memTerm ? {1'b0, sleepReqA[2:0]} : sleepReqA;
endmodule
`default_nettype wire

// ===== tb/bkrc_checker.sv
// Port checker for the regulator control block.
`timescale 1ns/100ps
`default_nettype none
module bkrc_checker
  import bkrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv1FullCurrent,
  input wire logic terminationEnable,
  input wire logic terminationRefOutEnable,
  input wire logic voltageReadyClear,
  input wire logic [NUM_CONV*CODE_W-1:0] convAppliedCode,
  input wire logic [NUM_CONV-1:0] convPowerOn,
  input wire logic [1:0] halfPassDisable,
  input wire logic conv4RefFromDac,
  input wire logic refBufferEnable,
  input wire logic pin0MemorySupplyInput,
  input wire logic pin1TerminationRefOutput,
  input wire logic [NUM_PINS-1:0] pinDigitalEnable,
  input wire logic voltageReadyEvent
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_half;
    $past(rst_n) |-> halfPassDisable[0] == !$past(conv1FullCurrent);
  endproperty
  a_half: assert property (p_half) else $error("half-current drive wrong");
  property p_dac;
    $past(rst_n) |-> conv4RefFromDac == !$past(terminationEnable);
  endproperty
  a_dac: assert property (p_dac) else $error("reference source wrong");
  property p_buf;
    $past(rst_n) |-> refBufferEnable == $past(terminationEnable && terminationRefOutEnable);
  endproperty
  a_buf: assert property (p_buf) else $error("reference buffer wrong");
  property p_pin0;
    $past(rst_n) |-> pin0MemorySupplyInput == $past(terminationEnable || terminationRefOutEnable)
      && pinDigitalEnable[0] != pin0MemorySupplyInput;
  endproperty
  a_pin0: assert property (p_pin0) else $error("first pin function wrong");
  property p_pin1;
    $past(rst_n) |-> pin1TerminationRefOutput == $past(terminationRefOutEnable)
      && pinDigitalEnable[1] != pin1TerminationRefOutput;
  endproperty
  a_pin1: assert property (p_pin1) else $error("second pin function wrong");
  property p_step;
    $past(rst_n) && $past(convPowerOn[0]) && convPowerOn[0] |->
      convAppliedCode[7:0] - $past(convAppliedCode[7:0]) inside {8'h00, 8'h01, 8'hff};
  endproperty
  a_step: assert property (p_step) else $error("code skipped a step");
  property p_sticky;
    voltageReadyEvent && !voltageReadyClear |=> voltageReadyEvent;
  endproperty
  a_sticky: assert property (p_sticky) else $error("ready flag dropped");
  property p_ready;
    $rose(voltageReadyEvent) |-> $stable(convAppliedCode);
  endproperty
  a_ready: assert property (p_ready) else $error("ready raised while ramping");
endmodule
`default_nettype wire

// ===== tb/bkrc_top_tb.sv
// Self-checking bench for the regulator control block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module bkrc_top_tb;
  import bkrc_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, powerModeSelectB = 1'b0, memTerm = 1'b0;
  logic slowStartupEnable = 1'b0, activeDischargeEnable = 1'b0, conv1FullCurrent = 1'b1;
  logic conv2FullCurrent = 1'b1, dualPhaseMerge = 1'b0, conv2PulldownDisable = 1'b0;
  logic terminationEnable = 1'b0, terminationRefOutEnable = 1'b0, voltageReadyClear = 1'b0;
  logic [3:0] convRegEnable = '0, seqStep = '0, convPresetSelect = '0, convPresetAuto = '0;
  logic [3:0] convCurrentLimitHit = '0, convSleepOnPresetB = '0, sleepReqA = '0;
  logic [3:0] convSeqEnable, convSleepOnPresetA, convPowerOn, convPresetBActive;
  logic [3:0] convDutyLimit, convForcePwm, convForcePfm, convAutoMode;
  logic [11:0] convEnablePinSel = 12'hfff, convPresetPinSel = 12'hfff;
  logic [4:0] pinLevel = '0, generalInputPin, pinDigitalEnable, generalInputValid;
  logic [31:0] convVoltagePresetA = 32'h0002_0304, convVoltagePresetB = 32'h0000_0007;
  logic [31:0] convAppliedCode;
  logic [7:0] modeReq = '0, convOperatingMode, convCurrentLimitSel = 8'h1b, convCurrentLimitOut;
  logic [1:0] slewStepSel = 2'h0, halfPassDisable;
  logic conv2PulldownOff, conv4RefFromSupplyHalf, conv4RefFromDac, refBufferEnable;
  logic pin0MemorySupplyInput, pin1TerminationRefOutput, voltageReadyEvent;
  logic [2:0] modeExp[4] = '{3'h4, 3'h2, 3'h4, 3'h1};
  logic [6:0] termExp[4] = '{7'h43, 7'h4c, 7'h2a, 7'h3c};
  int bad_count = 0, n_checks = 0, n;
  int stepCyc[4] = '{STEP_CYC_0, STEP_CYC_1, STEP_CYC_2, STEP_CYC_3};
  wire [6:0] termView = {conv4RefFromDac, conv4RefFromSupplyHalf, refBufferEnable,
    pin0MemorySupplyInput, pin1TerminationRefOutput, pinDigitalEnable[1:0]};
  bkrc_top i_bkrc_top (.*);
  bkrc_host_model i_bkrc_host_model (.*);
  initial forever #20 clk = ~clk;
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic idle(int k);
    repeat (k) @(negedge clk);
  endtask
  // Waits for a converter code; a stuck ramp ends the run.
  task automatic waitCode(int i, logic [7:0] v);
    int c;
    c = 0;
    while (convAppliedCode[i*8+:8] !== v) begin
      @(negedge clk);
      c++;
      if (c > 3000) begin
        bad_count++;
        print_verdict();
      end
    end
  endtask
  // Cycles between two code changes, after the first change is seen.
  task automatic period(int i, output int p);
    logic [7:0] c;
    for (int k = 0; k < 2; k++) begin
      c = convAppliedCode[i*8+:8];
      p = 0;
      while (convAppliedCode[i*8+:8] === c) begin
        @(negedge clk);
        p++;
        if (p > 1000) begin
          bad_count++;
          print_verdict();
        end
      end
    end
  endtask
  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    idle(1);
    `CHK({conv4RefFromDac, pinDigitalEnable, convAppliedCode}, {6'h3f, 32'h0})
    @(posedge clk);
    convRegEnable <= 4'h1;
    seqStep <= 4'h4;
    convEnablePinSel <= 12'hfdf;
    pinLevel <= 5'h08;
    idle(6);
    `CHK(convPowerOn, 4'h7)
    period(0, n);
    `CHK(n, START_STEP_CYC)
    `CHK(voltageReadyEvent, 1'b0)
    waitCode(0, 8'h04);
    idle(2);
    `CHK({voltageReadyEvent, convAppliedCode}, {1'b1, 32'h0002_0304})
    @(posedge clk);
    voltageReadyClear <= 1'b1;
    @(posedge clk);
    voltageReadyClear <= 1'b0;
    idle(3);
    `CHK(voltageReadyEvent, 1'b0)
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      slewStepSel <= s[1:0];
      convPresetSelect[0] <= ~convPresetSelect[0];
      period(0, n);
      `CHK(n, stepCyc[s])
      `CHK(convPresetBActive[0], ~s[0])
      waitCode(0, s[0] ? 8'h04 : 8'h07);
    end
    idle(2);
    `CHK(voltageReadyEvent, 1'b1)
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      modeReq[1:0] <= m[1:0];
      idle(3);
      `CHK({convForcePwm[0], convForcePfm[0], convAutoMode[0]}, modeExp[m])
    end
    @(posedge clk);
    modeReq[1:0] <= 2'h0;
    sleepReqA <= 4'h1;
    convCurrentLimitHit <= 4'h1;
    conv1FullCurrent <= 1'b0;
    dualPhaseMerge <= 1'b1;
    conv2PulldownDisable <= 1'b1;
    idle(4);
    `CHK({convForcePwm[0], convForcePfm[0], convAutoMode[0]}, 3'h2)
    `CHK({convDutyLimit[0], convPowerOn[0], convCurrentLimitOut}, 10'h31f)
    `CHK({halfPassDisable, conv2PulldownOff}, 3'h7)
    @(posedge clk);
    dualPhaseMerge <= 1'b0;
    pinLevel <= 5'h0b;
    idle(3);
    `CHK(halfPassDisable, 2'h1)
    for (int t = 0; t < 4; t++) begin
      @(posedge clk);
      {terminationEnable, terminationRefOutEnable} <= t[1:0];
      memTerm <= t[1];
      idle(3);
      `CHK(termView, termExp[t])
      `CHK(generalInputValid, 5'h0b & ~{3'h0, t[0], t[0] | t[1]})
    end
    @(posedge clk);
    convPresetAuto[1] <= 1'b1;
    powerModeSelectB <= 1'b1;
    convPresetPinSel <= 12'hedf;
    convSleepOnPresetB <= 4'h2;
    activeDischargeEnable <= 1'b1;
    convRegEnable <= 4'h0;
    idle(3);
    `CHK({convPresetBActive[2:1], convForcePfm[1]}, 3'h7)
    `CHK(convPowerOn[0], 1'b1)
    waitCode(0, 8'h00);
    idle(2);
    `CHK(convPowerOn[0], 1'b0)
    @(posedge clk);
    activeDischargeEnable <= 1'b0;
    seqStep <= 4'h0;
    idle(3);
    `CHK({convPowerOn[2], convAppliedCode[23:16]}, 9'h000)
    print_verdict();
  end
endmodule
bind bkrc_top bkrc_checker i_bkrc_checker (.*);
`default_nettype wire
